/* File: verilog/vtpg_map.svh */
// Register offsets, field positions, reset values and colour constants
// Assumes inclusion by bare name from the package and the generator files
`ifndef VTPG_MAP_SVH
`define VTPG_MAP_SVH

// ==========================================================
// Register offsets
`define VTPG_CTRL_ADDR 8'h64
`define VTPG_CFG_ADDR 8'h65
`define VTPG_RED_ADDR 8'h70
`define VTPG_GREEN_ADDR 8'h71
`define VTPG_BLUE_ADDR 8'h72
`define VTPG_FRAMES_ADDR 8'h73
`define VTPG_STATUS_ADDR 8'h74

// ==========================================================
// Reset values
`define VTPG_CTRL_RST 8'h10
`define VTPG_CFG_RST 5'h00
`define VTPG_FRAMES_RST 8'h3C

// ==========================================================
// Field positions
`define VTPG_CTRL_EN 0
`define VTPG_CTRL_REV 1
`define VTPG_CTRL_BARS 2
`define VTPG_CTRL_COMPL 3
`define VTPG_CFG_SCROLL 0
`define VTPG_CFG_INV 1
`define VTPG_CFG_SIX 4

// ==========================================================
// Pattern codes and colours
`define VTPG_SCROLL_FIRST 4'h1
`define VTPG_SCROLL_BANDS 4'hF
`define VTPG_POS_BITS 12
`define VTPG_SIX_MASK 24'hFCFCFC
`define VTPG_WHITE 24'hFFFFFF
`define VTPG_BLACK 24'h000000
`define VTPG_RED 24'hFF0000
`define VTPG_GREEN 24'h00FF00
`define VTPG_BLUE 24'h0000FF
`define VTPG_YELLOW 24'hFFFF00
`define VTPG_CYAN 24'h00FFFF
`define VTPG_MAGENTA 24'hFF00FF

`endif

/* File: verilog/vtpg_pkg.sv */
// Types shared by the test pattern generator files
// Assumes the map header sits beside it
`default_nettype none
`include "vtpg_map.svh"

package vtpg_pkg;

  // ==========================================================
  // Position counter state
  typedef struct packed {
    logic [`VTPG_POS_BITS-1:0] pos;
    logic [`VTPG_POS_BITS-1:0] span;
  } span_state_s;

  // ==========================================================
  // Generator state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] cfg;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] frames;
    logic [3:0] scroll_idx;
    logic [7:0] frame_cnt;
    logic de_d;
    logic vs_d;
    logic [23:0] rgb_o;
    logic de_o;
    logic vs_o;
    logic [7:0] rdata;
  } gen_state_s;

endpackage

`default_nettype wire

/* File: verilog/ramp_level.sv */
// Scales a position within a measured span onto evenly spread levels
// Assumes pos and span come from one clock domain; purely combinational
`timescale 1ns/1ps
`default_nettype none

module ramp_level #(
  parameter int LEVEL_BITS = 8,
  parameter int POS_BITS = 12
) (
  // Position and span
  input wire logic [POS_BITS-1:0] pos_i,
  input wire logic [POS_BITS-1:0] span_i,
  // Level
  output logic [LEVEL_BITS-1:0] level_o
);

  logic [POS_BITS+LEVEL_BITS-1:0] scaled;
  logic [POS_BITS+LEVEL_BITS-1:0] quot;

  // Clamp past the span: the first frame has no measured span yet
  always_comb begin
    scaled = {pos_i, {LEVEL_BITS{1'b0}}};
    quot = '0;
    if (pos_i >= span_i) begin
      quot = {(POS_BITS+LEVEL_BITS){1'b1}};
    end else begin
      quot = scaled / {{LEVEL_BITS{1'b0}}, span_i};
    end
    level_o = quot[LEVEL_BITS-1:0];
  end

endmodule

`default_nettype wire

/* File: verilog/span_counter.sv */
// Counts a position and keeps the span reached before the last restart
// Assumes inc and clr are on the same clock; clr is a one-cycle pulse, inc may be held high
`timescale 1ns/1ps
`default_nettype none
`include "vtpg_map.svh"

module span_counter
  import vtpg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic inc_i,
  input wire logic clr_i,
  // Results
  output logic [`VTPG_POS_BITS-1:0] pos_o,
  output logic [`VTPG_POS_BITS-1:0] span_o
);

  span_state_s st_reg;
  span_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (clr_i) begin
      st_next.span = st_reg.pos;
      st_next.pos = '0;
    end else if (inc_i && st_reg.pos != {`VTPG_POS_BITS{1'b1}}) begin
      st_next.pos = st_reg.pos + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pos_o = st_reg.pos;
  assign span_o = st_reg.span;

endmodule

`default_nettype wire

/* File: verilog/video_test_pattern_generator.sv */
// Video test pattern generator placed in front of the video output path
// Assumes video timing and pixels arrive on the pixel clock, registers on a plain port
//
// Behaviour
// - Fixed codes 1 to 5 give white, black, red, green, blue, or complements inverted.
// - Codes 6 to 9 give horizontal ramps from black to white or a primary.
// - Codes 10 to 13 give vertical ramps from black to white or a primary.
// - Code 14 gives the programmed custom colour, or its inversion.
// - Ramp steps spread evenly over the active width or height.
// - Auto scrolling makes the generator ignore the fixed selection.
// - The compliance bit selects the compliance pattern over the selection.
// - The colour bar bit gives eight bars white to black in fixed order.
// - The band order bit picks one of two orders of the four-band pattern.
// - The generator runs only while the control enable bit is set.
// - Six-bit mode gives 64 ramp levels and drives only the six top bits.
// - Otherwise patterns are 24-bit with 256 ramp levels.
// - Reset leaves selection code 1 and the control flag bits at zero.
// - Auto scrolling moves to the next pattern after the set frame count.
// - The invert bit complements the colour of every pattern.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "vtpg_map.svh"

module video_test_pattern_generator
  import vtpg_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Received video
  input wire logic [23:0] RGB_I,
  input wire logic DE_I,
  input wire logic VS_I,
  // Video toward the output path
  output logic [23:0] RGB_O,
  output logic DE_O,
  output logic VS_O
);

  // ==========================================================
  // State and derived controls
  gen_state_s st_reg;
  gen_state_s st_next;

  logic enable;
  logic auto_scroll;
  logic invert;
  logic six_bit;
  logic de_fall;
  logic vs_rise;
  logic [3:0] code;
  logic [`VTPG_POS_BITS-1:0] x_pos;
  logic [`VTPG_POS_BITS-1:0] x_span;
  logic [`VTPG_POS_BITS-1:0] y_pos;
  logic [`VTPG_POS_BITS-1:0] y_span;
  logic [7:0] h_level;
  logic [7:0] v_level;
  logic [2:0] bar_idx;
  logic [1:0] band_idx;
  logic [23:0] px;
  logic [23:0] ramp_mask;
  logic [7:0] ramp_lvl;

  assign enable = st_reg.ctrl[`VTPG_CTRL_EN];
  assign auto_scroll = st_reg.cfg[`VTPG_CFG_SCROLL];
  assign invert = st_reg.cfg[`VTPG_CFG_INV];
  assign six_bit = st_reg.cfg[`VTPG_CFG_SIX];
  assign de_fall = st_reg.de_d & ~DE_I;
  assign vs_rise = VS_I & ~st_reg.vs_d;
  // Scrolling index replaces the fixed selection
  assign code = auto_scroll ? st_reg.scroll_idx : st_reg.ctrl[7:4];

  // ==========================================================
  // Position tracking and even scaling
  span_counter u_x_cnt (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .inc_i(DE_I),
    .clr_i(de_fall),
    .pos_o(x_pos),
    .span_o(x_span)
  );

  span_counter u_y_cnt (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .inc_i(de_fall),
    .clr_i(vs_rise),
    .pos_o(y_pos),
    .span_o(y_span)
  );

  // Steps follow the measured active width and height
  ramp_level #(.LEVEL_BITS(8), .POS_BITS(`VTPG_POS_BITS)) u_h_ramp (
    .pos_i(x_pos),
    .span_i(x_span),
    .level_o(h_level)
  );

  ramp_level #(.LEVEL_BITS(8), .POS_BITS(`VTPG_POS_BITS)) u_v_ramp (
    .pos_i(y_pos),
    .span_i(y_span),
    .level_o(v_level)
  );

  ramp_level #(.LEVEL_BITS(3), .POS_BITS(`VTPG_POS_BITS)) u_bars (
    .pos_i(x_pos),
    .span_i(x_span),
    .level_o(bar_idx)
  );

  ramp_level #(.LEVEL_BITS(2), .POS_BITS(`VTPG_POS_BITS)) u_bands (
    .pos_i(x_pos),
    .span_i(x_span),
    .level_o(band_idx)
  );

  // ==========================================================
  // Pixel selection
  always_comb begin
    px = `VTPG_BLACK;
    ramp_mask = `VTPG_WHITE;
    ramp_lvl = h_level;
    unique case (code)
      4'h6, 4'hA: ramp_mask = `VTPG_WHITE;
      4'h7, 4'hB: ramp_mask = `VTPG_RED;
      4'h8, 4'hC: ramp_mask = `VTPG_GREEN;
      4'h9, 4'hD: ramp_mask = `VTPG_BLUE;
      default: ramp_mask = `VTPG_WHITE;
    endcase
    if (code >= 4'hA) begin
      ramp_lvl = v_level;
    end
    if (st_reg.ctrl[`VTPG_CTRL_COMPL]) begin
      // Alternating pixel checkerboard
      px = (x_pos[0] ^ y_pos[0]) ? `VTPG_WHITE : `VTPG_BLACK;
    end else if (st_reg.ctrl[`VTPG_CTRL_BARS]) begin
      unique case (bar_idx)
        3'h0: px = `VTPG_WHITE;
        3'h1: px = `VTPG_YELLOW;
        3'h2: px = `VTPG_CYAN;
        3'h3: px = `VTPG_GREEN;
        3'h4: px = `VTPG_MAGENTA;
        3'h5: px = `VTPG_RED;
        3'h6: px = `VTPG_BLUE;
        3'h7: px = `VTPG_BLACK;
      endcase
    end else begin
      unique case (code)
        4'h1: px = `VTPG_WHITE;
        4'h2: px = `VTPG_BLACK;
        4'h3: px = `VTPG_RED;
        4'h4: px = `VTPG_GREEN;
        4'h5: px = `VTPG_BLUE;
        4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: begin
          px = ramp_mask & {ramp_lvl, ramp_lvl, ramp_lvl};
        end
        4'hE: px = {st_reg.red, st_reg.green, st_reg.blue};
        4'hF: begin
          // Reserved as a fixed code; reached only by scrolling
          if (auto_scroll) begin
            unique case (band_idx)
              2'h0: px = st_reg.ctrl[`VTPG_CTRL_REV] ? `VTPG_BLUE : `VTPG_YELLOW;
              2'h1: px = `VTPG_CYAN;
              2'h2: px = st_reg.ctrl[`VTPG_CTRL_REV] ? `VTPG_YELLOW : `VTPG_BLUE;
              2'h3: px = `VTPG_RED;
            endcase
          end
        end
        4'h0: px = `VTPG_BLACK;
      endcase
    end
    if (invert) begin
      px = ~px;
    end
    // Low two bits of each channel forced low; ramps step in fours
    if (six_bit) begin
      px = px & `VTPG_SIX_MASK;
    end
  end

  // ==========================================================
  // Registers, scrolling and video path
  always_comb begin
    st_next = st_reg;
    st_next.de_d = DE_I;
    st_next.vs_d = VS_I;
    if (WR_I) begin
      unique case (ADDR_I)
        `VTPG_CTRL_ADDR: st_next.ctrl = WDATA_I;
        `VTPG_CFG_ADDR: st_next.cfg = WDATA_I[4:0];
        `VTPG_RED_ADDR: st_next.red = WDATA_I;
        `VTPG_GREEN_ADDR: st_next.green = WDATA_I;
        `VTPG_BLUE_ADDR: st_next.blue = WDATA_I;
        `VTPG_FRAMES_ADDR: st_next.frames = WDATA_I;
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end
    st_next.rdata = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        `VTPG_CTRL_ADDR: st_next.rdata = st_reg.ctrl;
        `VTPG_CFG_ADDR: st_next.rdata = {3'h0, st_reg.cfg};
        `VTPG_RED_ADDR: st_next.rdata = st_reg.red;
        `VTPG_GREEN_ADDR: st_next.rdata = st_reg.green;
        `VTPG_BLUE_ADDR: st_next.rdata = st_reg.blue;
        `VTPG_FRAMES_ADDR: st_next.rdata = st_reg.frames;
        `VTPG_STATUS_ADDR: st_next.rdata = {enable, auto_scroll, 2'h0, st_reg.scroll_idx};
        default: st_next.rdata = 8'h00;
      endcase
    end
    // A frame count of zero behaves as one
    if (enable && auto_scroll && vs_rise) begin
      if (st_reg.frame_cnt + 8'h01 >= st_reg.frames) begin
        st_next.frame_cnt = 8'h00;
        st_next.scroll_idx = (st_reg.scroll_idx == `VTPG_SCROLL_BANDS) ?
                             `VTPG_SCROLL_FIRST : st_reg.scroll_idx + 4'h1;
      end else begin
        st_next.frame_cnt = st_reg.frame_cnt + 8'h01;
      end
    end
    if (!enable) begin
      st_next.frame_cnt = 8'h00;
    end
    // One cycle of latency in both modes keeps timing aligned
    if (enable) begin
      st_next.rgb_o = px;
    end else begin
      st_next.rgb_o = RGB_I;
    end
    st_next.de_o = DE_I;
    st_next.vs_o = VS_I;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg <= '0;
      st_reg.ctrl <= `VTPG_CTRL_RST;
      st_reg.cfg <= `VTPG_CFG_RST;
      st_reg.frames <= `VTPG_FRAMES_RST;
      st_reg.scroll_idx <= `VTPG_SCROLL_FIRST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RGB_O = st_reg.rgb_o;
  assign DE_O = st_reg.de_o;
  assign VS_O = st_reg.vs_o;
  assign RDATA_O = st_reg.rdata;

  // ==========================================================
  // Checks
  logic fixed_plain;
  assign fixed_plain = enable & ~auto_scroll & ~st_reg.ctrl[3] & ~st_reg.ctrl[2] & ~six_bit;

  sequence s_read_ctrl;
    RD_I && ADDR_I == `VTPG_CTRL_ADDR;
  endsequence

  property p_reset_ctrl;
    @(posedge REF_CLK_I) $rose(RST_N_I) |-> st_reg.ctrl == `VTPG_CTRL_RST;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("control register not at reset value");

  property p_pass_through;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      !enable |=> RGB_O == $past(RGB_I);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("disabled generator altered video");

  property p_white;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      fixed_plain && !invert && st_reg.ctrl[7:4] == 4'h1 |=> RGB_O == 24'hFFFFFF;
  endproperty
  a_white: assert property (p_white)
    else $error("white field wrong");

  property p_invert_red;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      fixed_plain && invert && st_reg.ctrl[7:4] == 4'h3 |=> RGB_O == 24'h00FFFF;
  endproperty
  a_invert_red: assert property (p_invert_red)
    else $error("inverted red is not cyan");

  property p_six_bit;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      enable && six_bit |=> (RGB_O & 24'h030303) == 24'h000000;
  endproperty
  a_six_bit: assert property (p_six_bit)
    else $error("low colour bits driven in six-bit mode");

  property p_custom;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      fixed_plain && !invert && st_reg.ctrl[7:4] == 4'hE
      |=> RGB_O == {$past(st_reg.red), $past(st_reg.green), $past(st_reg.blue)};
  endproperty
  a_custom: assert property (p_custom)
    else $error("custom colour wrong");

  property p_compliance;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      enable && st_reg.ctrl[3] && !invert && !six_bit
      |=> RGB_O == 24'hFFFFFF || RGB_O == 24'h000000;
  endproperty
  a_compliance: assert property (p_compliance)
    else $error("compliance pattern not selected");

  property p_bar_first;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      enable && !st_reg.ctrl[3] && st_reg.ctrl[2] && !invert && !six_bit
      && x_pos == 12'h000 && x_span != 12'h000 |=> RGB_O == 24'hFFFFFF;
  endproperty
  a_bar_first: assert property (p_bar_first)
    else $error("first colour bar not white");

  property p_scroll_hold;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      !auto_scroll |=> $stable(st_reg.scroll_idx);
  endproperty
  a_scroll_hold: assert property (p_scroll_hold)
    else $error("pattern moved without scrolling");

  property p_read_ctrl;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
      s_read_ctrl |=> RDATA_O == $past(st_reg.ctrl) ##1 RDATA_O == 8'h00 || RD_I;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl)
    else $error("control read data wrong");

endmodule

`default_nettype wire

/* File: sim/video_source.sv */
// Far-side stand-in: small received video frames, pixel values moving every cycle
// Assumes one clock shared with the generator
`timescale 1ns/1ps
`default_nettype none

module video_source (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Video
  output logic [23:0] rgb_o,
  output logic de_o,
  output logic vs_o
);
  // ====================
  // Timing: 12 cycles a line, 8 active; 6 lines, line 0 sync, 1 to 4 active
  logic [3:0] h_reg;
  logic [2:0] v_reg;
  logic [7:0] n_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      h_reg <= 4'h0;
      v_reg <= 3'h0;
      n_reg <= 8'h00;
    end else begin
      n_reg <= n_reg + 8'h01;
      h_reg <= (h_reg == 4'hB) ? 4'h0 : h_reg + 4'h1;
      if (h_reg == 4'hB) begin
        v_reg <= (v_reg == 3'h5) ? 3'h0 : v_reg + 3'h1;
      end
    end
  end

  // ====================
  // Outputs; pixels never hold, so stale data cannot pass for a match
  assign de_o = (h_reg < 4'h8) && (v_reg != 3'h0) && (v_reg != 3'h5);
  assign vs_o = (v_reg == 3'h0);
  assign rgb_o = {n_reg, n_reg ^ 8'h5A, ~n_reg};
endmodule
`default_nettype wire

/* File: sim/video_test_pattern_generator_tb_top.sv */
// Self-checking bench for the test pattern generator
// Assumes the video source model and the map header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "vtpg_map.svh"

module video_test_pattern_generator_tb_top;
  // ====================
  // Signals
  logic ref_clk;
  logic rst_n;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, de_i, vs_i, de_o, vs_o;
  logic [23:0] rgb_i, rgb_o, rgb_d;
  logic [1:0] sync_d;
  int bad_count;
  int check_count;
  logic [3:0] e_sel;
  logic e_bars, e_compl, e_rev, e_inv, e_six, e_band;
  logic [23:0] e_cust;
  localparam logic [23:0] BAR_TAB [8] = '{`VTPG_WHITE, `VTPG_YELLOW, `VTPG_CYAN,
    `VTPG_GREEN, `VTPG_MAGENTA, `VTPG_RED, `VTPG_BLUE, `VTPG_BLACK};
  localparam logic [23:0] BAND_FWD [4] = '{`VTPG_YELLOW, `VTPG_CYAN, `VTPG_BLUE, `VTPG_RED};
  localparam logic [23:0] BAND_REV [4] = '{`VTPG_BLUE, `VTPG_CYAN, `VTPG_YELLOW, `VTPG_RED};

  video_test_pattern_generator video_test_pattern_generator_i (
    .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RGB_I(rgb_i), .DE_I(de_i),
    .VS_I(vs_i), .RGB_O(rgb_o), .DE_O(de_o), .VS_O(vs_o));
  video_source video_source_i (.clk_i(ref_clk), .rst_n_i(rst_n), .rgb_o(rgb_i),
    .de_o(de_i), .vs_o(vs_i));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // One-cycle copy of the received video for pass-through checks
  always @(posedge ref_clk) begin
    rgb_d <= rgb_i;
    sync_d <= {de_i, vs_i};
  end

  // ====================
  // Tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  task automatic reg_expect(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    check({16'h0000, d}, {16'h0000, e});
  endtask

  function automatic logic [23:0] exp_pix(input int x, input int y);
    logic [23:0] p;
    logic [7:0] lh;
    logic [7:0] lv;
    lh = 8'(x * 32);
    lv = 8'(y * 64);
    case (e_sel)
      4'h1: p = `VTPG_WHITE;
      4'h3: p = `VTPG_RED;
      4'h4: p = `VTPG_GREEN;
      4'h5: p = `VTPG_BLUE;
      4'h6: p = {lh, lh, lh};
      4'h7: p = {lh, 16'h0000};
      4'h8: p = {8'h00, lh, 8'h00};
      4'h9: p = {16'h0000, lh};
      4'hA: p = {lv, lv, lv};
      4'hB: p = {lv, 16'h0000};
      4'hC: p = {8'h00, lv, 8'h00};
      4'hD: p = {16'h0000, lv};
      4'hE: p = e_cust;
      default: p = `VTPG_BLACK;
    endcase
    if (e_band) p = e_rev ? BAND_REV[x / 2] : BAND_FWD[x / 2];
    if (e_bars) p = BAR_TAB[x];
    if (e_compl) p = (((x ^ y) & 1) != 0) ? `VTPG_WHITE : `VTPG_BLACK;
    if (e_inv) p = ~p;
    if (e_six) p = p & `VTPG_SIX_MASK;
    return p;
  endfunction

  task automatic wait_vs();
    int k;
    logic prev;
    prev = 1'b1;
    for (k = 0; k < 200; k++) begin
      @(negedge ref_clk);
      if (vs_o === 1'b1 && prev === 1'b0) return;
      prev = vs_o;
    end
    bad_count++;
    $display("ERROR at %0t: no frame start", $time);
  endtask

  // Whole frame: 4 lines of 8 pixels
  task automatic check_frame(input bit pass);
    int x;
    int y;
    int n;
    x = 0;
    y = 0;
    wait_vs();
    for (n = 0; n < 70; n++) begin
      @(negedge ref_clk);
      check({22'h0, de_o, vs_o}, {22'h0, sync_d});
      if (de_o === 1'b1) begin
        check(rgb_o, pass ? rgb_d : exp_pix(x, y));
        x++;
      end else if (x != 0) begin
        x = 0;
        y++;
      end
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ====================
  // Tests
  initial begin
    logic [7:0] st;
    logic [3:0] prev;
    int i;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    {e_sel, e_bars, e_compl, e_rev, e_inv, e_six, e_band} = '0;
    e_cust = 24'h57A93E;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_expect(`VTPG_CTRL_ADDR, 8'h10);
    reg_expect(`VTPG_CFG_ADDR, 8'h00);
    reg_expect(`VTPG_RED_ADDR, 8'h00);
    reg_expect(`VTPG_FRAMES_ADDR, 8'h3C);
    reg_expect(`VTPG_STATUS_ADDR, 8'h01);
    reg_expect(8'h66, 8'h00);
    reg_write(`VTPG_CFG_ADDR, 8'hFF);
    reg_expect(`VTPG_CFG_ADDR, 8'h1F);
    reg_write(`VTPG_CFG_ADDR, 8'h00);
    reg_write(`VTPG_RED_ADDR, 8'h57);
    reg_write(`VTPG_GREEN_ADDR, 8'hA9);
    reg_write(`VTPG_BLUE_ADDR, 8'h3E);
    reg_expect(`VTPG_GREEN_ADDR, 8'hA9);
    check_frame(1'b1);
    $display("registers and pass-through done");
    // Unmapped place here; transmitter power-down precedes enabling
    reg_write(8'h63, 8'h01);
    reg_expect(8'h63, 8'h00);
    for (i = 0; i < 32; i++) begin
      e_sel = i[3:0];
      e_inv = i[4];
      reg_write(`VTPG_CFG_ADDR, {6'h00, e_inv, 1'b0});
      reg_write(`VTPG_CTRL_ADDR, {e_sel, 4'h1});
      check_frame(1'b0);
    end
    $display("fixed codes done");
    e_six = 1'b1;
    e_inv = 1'b1;
    reg_write(`VTPG_CFG_ADDR, 8'h12);
    for (i = 0; i < 3; i++) begin
      e_sel = (i == 0) ? 4'h6 : (i == 1) ? 4'hA : 4'hE;
      reg_write(`VTPG_CTRL_ADDR, {e_sel, 4'h1});
      check_frame(1'b0);
    end
    {e_six, e_inv, e_sel, e_bars} = {2'b00, 4'h3, 1'b1};
    reg_write(`VTPG_CFG_ADDR, 8'h00);
    reg_write(`VTPG_CTRL_ADDR, 8'h35);
    check_frame(1'b0);
    e_compl = 1'b1;
    reg_write(`VTPG_CTRL_ADDR, 8'h3D);
    check_frame(1'b0);
    e_inv = 1'b1;
    reg_write(`VTPG_CFG_ADDR, 8'h02);
    check_frame(1'b0);
    {e_inv, e_compl, e_bars} = 3'b000;
    $display("bars and compliance done");
    reg_write(`VTPG_FRAMES_ADDR, 8'h01);
    reg_write(`VTPG_CTRL_ADDR, 8'h31);
    reg_write(`VTPG_CFG_ADDR, 8'h01);
    prev = 4'h0;
    for (i = 0; i < 20 && prev !== 4'hF; i++) begin
      wait_vs();
      reg_read(`VTPG_STATUS_ADDR, st);
      if (prev !== 4'h0) check({16'h0000, st}, {16'h0000, 4'hC, prev + 4'h1});
      prev = st[3:0];
    end
    // Long frame time freezes the index on the band pattern
    reg_write(`VTPG_FRAMES_ADDR, 8'hFF);
    e_band = 1'b1;
    check_frame(1'b0);
    e_rev = 1'b1;
    reg_write(`VTPG_CTRL_ADDR, 8'h33);
    check_frame(1'b0);
    e_band = 1'b0;
    reg_write(`VTPG_CFG_ADDR, 8'h00);
    reg_expect(`VTPG_STATUS_ADDR, 8'h8F);
    check_frame(1'b0);
    reg_write(`VTPG_CTRL_ADDR, 8'h30);
    check_frame(1'b1);
    $display("scrolling and bands done");
    complete_run();
  end

  // Tests take about 7500 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
